// [cqr_top.sv]
// cqr_top: decodes capability and version-tail queries, answers in words
// assumes: header, checksum and framing are handled by neighbouring logic;
// a command arrives as a one-cycle strobe with its type code
`timescale 1ns/1ps
`default_nettype none
module cqr_top
    import cqr_pkg::*;
#(
    parameter int BUF_BYTES = 0,
    parameter int CHANNELS = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // command strobe from the packet parser
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_type,
    input wire logic i_cmd_error,
    // capability straps
    input wire logic i_hw_arb_cap,
    input wire logic i_drv_status_cap,
    input wire logic i_fc_to_mc_cap,
    input wire logic i_fc_from_mc_cap,
    input wire logic i_all_mc_cap,
    input wire logic i_global_mc_cmd_cap,
    input wire logic [1:0] i_hw_arb_status,
    input wire logic i_thermal_cap,
    input wire logic i_delayed_rsp_cap,
    input wire logic [31:0] i_bcast_filter_cap,
    input wire logic [31:0] i_mcast_filter_cap,
    input wire logic [31:0] i_async_event_notice_cap,
    input wire logic [7:0] i_vlan_filters,
    input wire logic [7:0] i_mixed_filters,
    input wire logic [7:0] i_mcast_filters,
    input wire logic [7:0] i_ucast_filters,
    input wire logic [2:0] i_vlan_modes,
    // version-tail enterprise number
    input wire logic i_mfr_id_used,
    input wire logic [31:0] i_mfr_id,
    // response word stream
    output logic o_rsp_valid,
    output logic [31:0] o_rsp_data,
    output logic o_rsp_last,
    output logic [7:0] o_rsp_type,
    output logic o_cmd_dropped
);
    localparam logic [31:0] BUF_BYTES_W = 32'(BUF_BYTES);
    localparam logic [7:0] CHANNELS_W = 8'(CHANNELS);

    cqr_word_if wif ();

    logic [31:0] flags;
    logic [1:0] arb_status;
    logic [31:0] caps_words [0:7];
    logic [31:0] ver_words [0:7];
    logic is_caps, is_ver, accept;
    logic rsp_valid_q, rsp_valid_d;
    logic [31:0] rsp_data_q, rsp_data_d;
    logic rsp_last_q, rsp_last_d;
    logic [7:0] rsp_type_q, rsp_type_d;
    logic [7:0] pend_type_q, pend_type_d;
    logic dropped_q, dropped_d;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    // an erroneous request gets no answer here; the parser sends the error reply
    assign is_caps = i_cmd_valid && !i_cmd_error && (i_cmd_type == CQR_CMD_GET_CAPS);
    // is the controller's framing; only the type code is consulted here
    assign is_ver = i_cmd_valid && !i_cmd_error && (i_cmd_type == CQR_CMD_GET_VER);
    assign accept = (is_caps || is_ver) && !wif.busy;

    // ---------------------------------------------------------------
    // capability flag word
    // ---------------------------------------------------------------
    // reserved arbitration code is never reported; fall back to unknown
    assign arb_status = (i_hw_arb_status == CQR_ARB_RESERVED) ? CQR_ARB_UNKNOWN : i_hw_arb_status;

    always_comb begin
        flags = 32'h00000000;
        flags[CQR_FLG_HW_ARB] = i_hw_arb_cap;
        flags[CQR_FLG_DRV_STAT] = i_drv_status_cap;
        flags[CQR_FLG_FC_TX] = i_fc_to_mc_cap;
        flags[CQR_FLG_FC_RX] = i_fc_from_mc_cap;
        // both halves must hold, else the bit is meaningless to the controller
        flags[CQR_FLG_ALL_MC] = i_all_mc_cap && i_global_mc_cmd_cap;
        flags[CQR_FLG_ARB_LO +: 2] = arb_status;
        flags[CQR_FLG_THERM] = i_thermal_cap;
        flags[CQR_FLG_DELAY] = i_delayed_rsp_cap;
    end

    // ---------------------------------------------------------------
    // payload assembly, word 0 is response and reason codes
    // ---------------------------------------------------------------
    always_comb begin
        caps_words[0] = {CQR_RSP_COMPLETED, CQR_REASON_NONE};
        caps_words[1] = flags;
        caps_words[2] = i_bcast_filter_cap;
        caps_words[3] = i_mcast_filter_cap;
        // zero parameter already means unspecified size
        caps_words[4] = BUF_BYTES_W;
        caps_words[5] = i_async_event_notice_cap;
        caps_words[6] = {i_vlan_filters, i_mixed_filters, i_mcast_filters, i_ucast_filters};
        caps_words[7] = {16'h0000, 5'h00, i_vlan_modes & CQR_VLAN_MODE_MASK, CHANNELS_W};
    end

    // version response tail: codes then enterprise number only
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ver_words[i] = 32'h00000000;
        end
        ver_words[0] = {CQR_RSP_COMPLETED, CQR_REASON_NONE};
        ver_words[1] = i_mfr_id_used ? i_mfr_id : CQR_MFR_UNUSED;
    end

    // ---------------------------------------------------------------
    // hand payload to the emitter
    // ---------------------------------------------------------------
    assign wif.load = accept;
    // chosen word by word; a whole-array select is not taken by every tool
    for (genvar k = 0; k < 8; k++) begin : g_words
        assign wif.words[k] = is_caps ? caps_words[k] : ver_words[k];
    end
    assign wif.count = is_caps ? 4'(CQR_CAPS_WORDS) : 4'(CQR_VER_TAIL_WORDS);

    cqr_emitter u_emit (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .bus(wif)
    );

    // ---------------------------------------------------------------
    // output staging: registered copy of the emitter stream
    // ---------------------------------------------------------------
    always_comb begin
        pend_type_d = pend_type_q;
        if (accept) begin
            pend_type_d = is_caps ? CQR_RSP_GET_CAPS : CQR_RSP_GET_VER;
        end
        rsp_valid_d = wif.valid;
        rsp_data_d = wif.valid ? wif.data : 32'h00000000;
        rsp_last_d = wif.last;
        rsp_type_d = wif.valid ? pend_type_q : 8'h00;
        // a request while a reply is still going out is lost; flag it for one cycle
        dropped_d = (is_caps || is_ver) && wif.busy;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 32'h00000000;
            rsp_last_q <= 1'b0;
            rsp_type_q <= 8'h00;
            pend_type_q <= 8'h00;
            dropped_q <= 1'b0;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            rsp_last_q <= rsp_last_d;
            rsp_type_q <= rsp_type_d;
            pend_type_q <= pend_type_d;
            dropped_q <= dropped_d;
        end
    end

    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_data = rsp_data_q;
    assign o_rsp_last = rsp_last_q;
    assign o_rsp_type = rsp_type_q;
    assign o_cmd_dropped = dropped_q;
endmodule
`default_nettype wire

// [cqr_pkg.sv]
// cqr_pkg: constants for the capability query responder
// assumes: included first in compile order; no other dependencies
package cqr_pkg;
    // ---------------------------------------------------------------
    // command and response codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CQR_CMD_GET_CAPS = 8'h16;
    localparam logic [7:0] CQR_RSP_GET_CAPS = 8'h96;
    localparam logic [7:0] CQR_CMD_GET_VER = 8'h15;
    localparam logic [7:0] CQR_RSP_GET_VER = 8'h95;
    localparam logic [15:0] CQR_RSP_COMPLETED = 16'h0000;
    localparam logic [15:0] CQR_RSP_UNAVAIL = 16'h0002;
    localparam logic [15:0] CQR_REASON_NONE = 16'h0000;
    localparam logic [15:0] CQR_REASON_BUSY = 16'h0005;
    localparam logic [31:0] CQR_MFR_UNUSED = 32'hffffffff;
    // ---------------------------------------------------------------
    // capability flag bit positions
    // ---------------------------------------------------------------
    localparam int CQR_FLG_HW_ARB = 0;
    localparam int CQR_FLG_DRV_STAT = 1;
    localparam int CQR_FLG_FC_TX = 2;
    localparam int CQR_FLG_FC_RX = 3;
    localparam int CQR_FLG_ALL_MC = 4;
    localparam int CQR_FLG_ARB_LO = 5;
    localparam int CQR_FLG_THERM = 7;
    localparam int CQR_FLG_DELAY = 8;
    localparam logic [1:0] CQR_ARB_RESERVED = 2'h3;
    localparam logic [1:0] CQR_ARB_UNKNOWN = 2'h0;
    // ---------------------------------------------------------------
    // response layout: payload words after the 16-byte header
    // ---------------------------------------------------------------
    localparam int CQR_CAPS_WORDS = 8;
    localparam int CQR_VER_TAIL_WORDS = 2;
    localparam logic [2:0] CQR_VLAN_MODE_MASK = 3'h7;
    localparam int CQR_MAX_ADDR_FILTERS = 8;
    localparam int CQR_MAX_VLAN_FILTERS = 15;
    // ---------------------------------------------------------------
    // emitter states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CQR_IDLE = 2'b00,
        CQR_EMIT = 2'b01,
        CQR_LAST = 2'b10
    } cqr_state_type;
endpackage

// [cqr_word_if.sv]
// cqr_word_if: response word stream between the responder and its emitter
// assumes: one clock domain; producer holds data until accepted
`timescale 1ns/1ps
`default_nettype none
interface cqr_word_if;
    logic load;
    logic [31:0] words [0:7];
    logic [3:0] count;
    logic busy;
    logic valid;
    logic [31:0] data;
    logic last;
    modport src (output load, output words, output count, input busy, input valid, input data, input last);
    modport emit (input load, input words, input count, output busy, output valid, output data, output last);
endinterface
`default_nettype wire

// [cqr_emitter.sv]
// cqr_emitter: serialises a latched response payload one word per clock
// assumes: load is raised only while busy is low
`timescale 1ns/1ps
`default_nettype none
module cqr_emitter
    import cqr_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // word stream
    cqr_word_if.emit bus
);
    cqr_state_type state_q, state_d;
    logic [31:0] buf_q [0:7];
    logic [31:0] buf_d [0:7];
    logic [3:0] idx_q, idx_d;
    logic [3:0] cnt_q, cnt_d;

    // ---------------------------------------------------------------
    // next state: latch whole payload so inputs may change mid-packet
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        buf_d = buf_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        case (state_q)
            CQR_IDLE: begin
                if (bus.load) begin
                    buf_d = bus.words;
                    cnt_d = bus.count;
                    idx_d = 4'h0;
                    state_d = (bus.count == 4'h1) ? CQR_LAST : CQR_EMIT;
                end
            end
            CQR_EMIT: begin
                idx_d = idx_q + 4'h1;
                if (idx_q + 4'h2 == cnt_q) begin
                    state_d = CQR_LAST;
                end
            end
            CQR_LAST: begin
                state_d = CQR_IDLE;
            end
            default: begin
                state_d = CQR_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= CQR_IDLE;
            idx_q <= 4'h0;
            cnt_q <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                buf_q[i] <= 32'h00000000;
            end
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            buf_q <= buf_d;
        end
    end

    // outputs read straight from state and buffer
    assign bus.busy = (state_q != CQR_IDLE);
    assign bus.valid = (state_q != CQR_IDLE);
    assign bus.data = buf_q[idx_q[2:0]];
    assign bus.last = (state_q == CQR_LAST);
endmodule
`default_nettype wire

// [cqr_props.sv]
// cqr_props: port checks for the capability query responder
// assumes: bound to cqr_top, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module cqr_props
    import cqr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_type,
    input wire logic i_cmd_error,
    input wire logic i_mfr_id_used,
    input wire logic [31:0] i_mfr_id,
    input wire logic o_rsp_valid,
    input wire logic [31:0] o_rsp_data,
    input wire logic o_rsp_last,
    input wire logic [7:0] o_rsp_type,
    input wire logic o_cmd_dropped
);
    logic [3:0] busy_q, busy_d;
    logic known, take;
    // edges still refused: one per word, since the last word's cycle still counts as busy
    assign known = i_cmd_valid && !i_cmd_error && (i_cmd_type == CQR_CMD_GET_CAPS || i_cmd_type == CQR_CMD_GET_VER);
    assign take = known && busy_q == 4'h0;
    always_comb begin
        busy_d = (busy_q != 4'h0) ? busy_q - 4'h1 : 4'h0;
        if (take) begin
            busy_d = (i_cmd_type == CQR_CMD_GET_CAPS) ? 4'(CQR_CAPS_WORDS) : 4'(CQR_VER_TAIL_WORDS);
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_q <= 4'h0;
        end else begin
            busy_q <= busy_d;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    chk_caps_head: assert property (
        take && i_cmd_type == CQR_CMD_GET_CAPS |-> ##2 o_rsp_valid && o_rsp_type == CQR_RSP_GET_CAPS
        && o_rsp_data == 32'h0) else $error("capability reply head wrong");
    chk_caps_len: assert property (
        take && i_cmd_type == CQR_CMD_GET_CAPS |-> ##2 (o_rsp_valid && !o_rsp_last) [*7]
        ##1 (o_rsp_valid && o_rsp_last)) else $error("capability reply length wrong");
    chk_ver_tail: assert property (
        take && i_cmd_type == CQR_CMD_GET_VER |-> ##2 (o_rsp_valid && o_rsp_type == CQR_RSP_GET_VER)
        ##1 (o_rsp_last && o_rsp_data == ($past(i_mfr_id_used, 3) ? $past(i_mfr_id, 3) : CQR_MFR_UNUSED)))
        else $error("version tail wrong");
    chk_ignore_other: assert property (
        i_cmd_valid && !take && busy_q == 4'h0 |-> ##2 !o_rsp_valid) else $error("ignored command answered");
    chk_drop_pulse: assert property (
        known && busy_q != 4'h0 |=> o_cmd_dropped) else $error("busy command not flagged");
    chk_drop_cause: assert property (
        o_cmd_dropped |-> $past(known && busy_q != 4'h0)) else $error("drop flag without cause");
    chk_flag_word: assert property (
        o_rsp_valid && $past(o_rsp_valid) && !$past(o_rsp_valid, 2) && o_rsp_type == CQR_RSP_GET_CAPS
        |-> o_rsp_data[6:5] != CQR_ARB_RESERVED && o_rsp_data[31:9] == 23'h0) else $error("flag word bad");
    chk_idle_quiet: assert property (
        !o_rsp_valid |-> o_rsp_data == 32'h0 && o_rsp_type == 8'h0 && !o_rsp_last) else $error("idle not zero");
endmodule
bind cqr_top cqr_props u_props (.i_clk, .i_arst_n, .i_cmd_valid, .i_cmd_type, .i_cmd_error, .i_mfr_id_used,
    .i_mfr_id, .o_rsp_valid, .o_rsp_data, .o_rsp_last, .o_rsp_type, .o_cmd_dropped);
`default_nettype wire

// [cqr_mc_model.sv]
// cqr_mc_model: management controller side, issues command strobes
// assumes: send is called just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module cqr_mc_model (
    // clock
    input wire logic i_clk,
    // command strobe toward the responder
    output var logic o_cmd_valid,
    output var logic [7:0] o_cmd_type,
    output var logic o_cmd_error
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_type = 8'h00;
        o_cmd_error = 1'b0;
    end
    // reported buffering size is not used for deselect timing here, which is optional
    // framing and checksum are checked upstream, so only the code is sent
    task automatic send(input logic [7:0] t, input logic e, input int n);
        o_cmd_valid = 1'b1;
        o_cmd_type = t;
        o_cmd_error = e;
        repeat (n) @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd_type = ~t; // idle code inverted so a stale value never looks valid
        o_cmd_error = 1'b0;
    endtask
endmodule
`default_nettype wire

// [cqr_top_test.sv]
// cqr_top_test: self-checking bench for the capability query responder
// assumes: package, interface, design, checker and controller model compiled first
`timescale 1ns/1ps
`default_nettype none
module cqr_top_test
    import cqr_pkg::*;
;
    localparam int CHANS = 3;
    localparam logic [31:0] MFR_ID = 32'h0000_abcd; // arbitrary value
    logic i_clk, i_arst_n, cmd_valid, cmd_error, mfr_used, rsp_valid, rsp_last, dropped;
    logic [7:0] cmd_type, rsp_type, vlan_f, mixed_f, mc_f, uc_f;
    logic [9:0] s;
    logic [2:0] vmodes;
    logic [31:0] bc, mc, evt, rsp_data;
    logic [31:0] w [8];
    logic [40:0] q [$];
    int err_count = 0, samples_checked = 0, cyc = 0;
    // straps {delay,thermal,arb[1:0],gmc,allmc,fc_in,fc_out,drv,arb_cap} beside the flag word they give
    logic [41:0] rows [14] = '{{10'h000, 32'h000}, {10'h001, 32'h001}, {10'h002, 32'h002}, {10'h004, 32'h004},
        {10'h008, 32'h008}, {10'h010, 32'h000}, {10'h020, 32'h000}, {10'h030, 32'h010}, {10'h040, 32'h020},
        {10'h080, 32'h040}, {10'h0c0, 32'h000}, {10'h100, 32'h080}, {10'h200, 32'h100}, {10'h3ff, 32'h19f}};
    cqr_mc_model u_cqr_mc_model (.i_clk(i_clk), .o_cmd_valid(cmd_valid), .o_cmd_type(cmd_type),
        .o_cmd_error(cmd_error));
    cqr_top #(.BUF_BYTES(0), .CHANNELS(CHANS)) u_cqr_top (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_cmd_valid(cmd_valid), .i_cmd_type(cmd_type), .i_cmd_error(cmd_error), .i_hw_arb_cap(s[0]),
        .i_drv_status_cap(s[1]), .i_fc_to_mc_cap(s[2]), .i_fc_from_mc_cap(s[3]), .i_all_mc_cap(s[4]),
        .i_global_mc_cmd_cap(s[5]), .i_hw_arb_status(s[7:6]), .i_thermal_cap(s[8]), .i_delayed_rsp_cap(s[9]),
        .i_bcast_filter_cap(bc), .i_mcast_filter_cap(mc), .i_async_event_notice_cap(evt), .i_vlan_filters(vlan_f),
        .i_mixed_filters(mixed_f), .i_mcast_filters(mc_f), .i_ucast_filters(uc_f), .i_vlan_modes(vmodes),
        .i_mfr_id_used(mfr_used), .i_mfr_id(MFR_ID), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .o_rsp_last(rsp_last), .o_rsp_type(rsp_type), .o_cmd_dropped(dropped));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // every presented word is queued as {last, type, data}
    always @(posedge i_clk) begin
        if (rsp_valid === 1'b1) q.push_back({rsp_last, rsp_type, rsp_data});
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // waits a bounded time for n words, then compares them with w
    task automatic expect_rsp(input logic [7:0] t, input int n);
        logic [40:0] e;
        int k;
        k = 0;
        while (q.size() < n && k < 20) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk("count", n, q.size());
        for (int j = 0; j < n && q.size() > 0; j++) begin
            e = q.pop_front();
            chk("type", t, e[39:32]);
            chk("last", (j == n - 1), e[40]);
            chk("word", w[j], e[31:0]);
        end
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_arst_n, mfr_used, s, bc, mc, evt, vlan_f, uc_f, vmodes} = '0;
        mixed_f = 8'h01;
        mc_f = 8'h02;
        repeat (4) @(posedge i_clk);
        #1;
        i_arst_n = 1'b1;
        for (int i = 0; i < 14; i++) begin
            s = rows[i][41:32];
            bc = {8'h5a, 24'(i)};
            mc = ~bc;
            evt = {24'(i), 8'hc3};
            vlan_f = 8'(i);
            uc_f = 8'(i % 3 + 1);
            vmodes = 3'(i);
            w = '{32'h0, rows[i][31:0], bc, mc, 32'h0, evt, {vlan_f, mixed_f, mc_f, uc_f}, {21'h0, vmodes, 8'(CHANS)}};
            u_cqr_mc_model.send(CQR_CMD_GET_CAPS, 1'b0, 1);
            expect_rsp(CQR_RSP_GET_CAPS, 8);
        end
        $display("test rows done, %0d errors", err_count);
        mfr_used = 1'b1;
        w[1] = MFR_ID;
        u_cqr_mc_model.send(CQR_CMD_GET_VER, 1'b0, 1);
        expect_rsp(CQR_RSP_GET_VER, 2);
        // two tails at the closest spacing allowed; the last word's cycle still refuses
        mfr_used = 1'b0;
        w[1] = CQR_MFR_UNUSED;
        u_cqr_mc_model.send(CQR_CMD_GET_VER, 1'b0, 1);
        repeat (2) @(posedge i_clk);
        #1;
        u_cqr_mc_model.send(CQR_CMD_GET_VER, 1'b0, 1);
        expect_rsp(CQR_RSP_GET_VER, 2);
        expect_rsp(CQR_RSP_GET_VER, 2);
        $display("test version done, %0d errors", err_count);
        w[1] = 32'h19f;
        // drop flag stands only in the cycle after the refused strobe edge
        u_cqr_mc_model.send(CQR_CMD_GET_CAPS, 1'b0, 2);
        chk("dropped", 1, dropped);
        expect_rsp(CQR_RSP_GET_CAPS, 8);
        u_cqr_mc_model.send(CQR_CMD_GET_CAPS, 1'b1, 1);
        @(posedge i_clk);
        #1;
        u_cqr_mc_model.send(8'h17, 1'b0, 1);
        repeat (6) @(posedge i_clk);
        #1;
        chk("extra", 0, q.size());
        $display("test refusals done, %0d errors", err_count);
        // reset in mid-reply must silence the stream at once
        u_cqr_mc_model.send(CQR_CMD_GET_CAPS, 1'b0, 1);
        repeat (4) @(posedge i_clk);
        #1;
        i_arst_n = 1'b0;
        #1;
        chk("reset", 0, {rsp_valid, rsp_last, dropped, rsp_type});
        chk("reset data", 0, rsp_data);
        @(posedge i_clk);
        #1;
        i_arst_n = 1'b1;
        q.delete();
        u_cqr_mc_model.send(CQR_CMD_GET_CAPS, 1'b0, 1);
        expect_rsp(CQR_RSP_GET_CAPS, 8);
        $display("test reset done, %0d errors", err_count);
        summarize();
    end
endmodule
`default_nettype wire
